// ### src/arct_pkg.sv
// holds constants, field layouts and types of the auto-reload capture timer
// assumes a single 20 MHz core clock and a 32-bit avalon-mm register bus
package arct_pkg;

  // ****************************************************************
  // register map, byte addresses on the bus
  // ****************************************************************
  localparam int          ARCT_ADDR_W    = 5;
  localparam logic [4:0]  ARCT_OFS_CTRL  = 5'h00;
  localparam logic [4:0]  ARCT_OFS_CKSEL = 5'h04;
  localparam logic [4:0]  ARCT_OFS_RLLO  = 5'h08;
  localparam logic [4:0]  ARCT_OFS_RLHI  = 5'h0C;
  localparam logic [4:0]  ARCT_OFS_CNTLO = 5'h10;
  localparam logic [4:0]  ARCT_OFS_CNTHI = 5'h14;
  localparam logic [4:0]  ARCT_OFS_IRQEN = 5'h18;

  // ****************************************************************
  // reset values and byte limits
  // ****************************************************************
  localparam logic [7:0]  ARCT_BYTE_RST  = 8'h00;
  localparam logic [7:0]  ARCT_BYTE_MAX  = 8'hFF;
  localparam logic [7:0]  ARCT_BYTE_ONE  = 8'h01;
  localparam logic [15:0] ARCT_WORD_ZERO = 16'h0000;
  localparam logic [31:0] ARCT_RD_ZERO   = 32'h0000_0000;

  // ****************************************************************
  // clock source encodings and divider counts
  // ****************************************************************
  localparam logic [1:0]  ARCT_ALT_DIV12A = 2'h0;
  localparam logic [1:0]  ARCT_ALT_EXT8   = 2'h1;
  localparam logic [1:0]  ARCT_ALT_DIV12B = 2'h2;
  localparam logic [1:0]  ARCT_ALT_CMP    = 2'h3;
  localparam int          ARCT_CORE_DIV   = 12;
  localparam int          ARCT_EXT_DIV    = 8;
  localparam logic [3:0]  ARCT_DIV12_LAST = 4'(ARCT_CORE_DIV - 1);
  localparam logic [3:0]  ARCT_DIV12_RST  = 4'h0;
  localparam logic [2:0]  ARCT_DIV8_LAST  = 3'(ARCT_EXT_DIV - 1);
  localparam logic [2:0]  ARCT_DIV8_RST   = 3'h0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic       ovf_flag_high;
    logic       ovf_flag_low;
    logic       low_ovf_irq_en;
    logic       capture_mode_en;
    logic       split_mode_sel;
    logic       run_high;
    logic [1:0] alt_clock_sel;
  } arct_ctrl_s;

  typedef struct packed {
    logic [5:0] unused;
    logic       high_core_clock_sel;
    logic       low_core_clock_sel;
  } arct_cksel_s;

  localparam arct_ctrl_s  ARCT_CTRL_RST  = '0;
  localparam arct_cksel_s ARCT_CKSEL_RST = '0;

  // bus answer: one wait cycle, then the acknowledge cycle
  typedef enum logic [1:0] {
    ARCT_BUS_IDLE = 2'b00,
    ARCT_BUS_ACK  = 2'b01
  } arct_bus_e;

endpackage

// ### src/arct_sync_edge.sv
// holds a two-stage synchroniser with a rising edge pulse behind it
// assumes the input may change at any time relative to clk_sys
`timescale 1ns/100ps
module arct_sync_edge
  import arct_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic sig_in,
  output logic      rise_pulse
);

  logic meta_ff, stab_ff, prev_ff;
  logic nxt_meta, nxt_stab, nxt_prev;
  // the check below trusts no input history from before reset release
  localparam logic [1:0] AGE_FULL = 2'h3;
  logic [1:0] age_ff, nxt_age;

  // ****************************************************************
  // synchroniser, first stage feeds only the second
  // ****************************************************************
  always_comb begin
    nxt_meta = sig_in;
    nxt_stab = meta_ff;
    nxt_prev = stab_ff;
    nxt_age  = (age_ff == AGE_FULL) ? AGE_FULL : 2'(age_ff + 2'h1);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      stab_ff <= 1'b0;
      prev_ff <= 1'b0;
      age_ff  <= 2'h0;
    end else begin
      meta_ff <= nxt_meta;
      stab_ff <= nxt_stab;
      prev_ff <= nxt_prev;
      age_ff  <= nxt_age;
    end
  end

  assign rise_pulse = stab_ff & ~prev_ff;

  a_sync_rise_delay : assert property (
    @(posedge clk_sys) disable iff (rst)
    ((age_ff == AGE_FULL) && rise_pulse) |-> ($past(sig_in, 2) && !$past(sig_in, 3)))
    else $error("edge pulse not two cycles behind input rise");

endmodule // arct_sync_edge

// ### src/arct_top.sv
// holds the auto-reload capture timer with its avalon-mm register slave
// assumes comparator and external oscillator inputs are asynchronous levels
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module arct_top
  import arct_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [ARCT_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   cmp1_in,
  input  wire logic                   ext_osc_in,
  output logic                        timer_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  arct_bus_e   bus_ff,      nxt_bus;
  logic [31:0] rdata_ff,    nxt_rdata;
  arct_ctrl_s  ctrl_ff,     nxt_ctrl;
  arct_cksel_s cksel_ff,    nxt_cksel;
  logic        irq_en_ff,   nxt_irq_en;
  logic        irq_ff,      nxt_irq;
  logic [7:0]  cnt_lo_ff,   nxt_cnt_lo;
  logic [7:0]  cnt_hi_ff,   nxt_cnt_hi;
  logic [7:0]  rl_lo_ff,    nxt_rl_lo;
  logic [7:0]  rl_hi_ff,    nxt_rl_hi;
  logic [3:0]  div12_ff,    nxt_div12;
  logic [2:0]  div8_ff,     nxt_div8;

  logic        cmp_rise;
  logic        ext_rise;
  logic        tick_div12;
  logic        tick_ext8;
  logic        alt_tick;
  logic        tick_lo;
  logic        tick_hi;
  logic        cap_event;
  logic        wr_take;
  logic        wr_lane;
  logic        set_h;
  logic        set_l;

  // ****************************************************************
  // source synchronisers
  // ****************************************************************
  arct_sync_edge u_sync_cmp (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .sig_in     (cmp1_in),
    .rise_pulse (cmp_rise)
  );

  arct_sync_edge u_sync_ext (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .sig_in     (ext_osc_in),
    .rise_pulse (ext_rise)
  );

  // ****************************************************************
  // prescalers and source selection
  // ****************************************************************
  always_comb begin
    nxt_div12 = (div12_ff == ARCT_DIV12_LAST) ? ARCT_DIV12_RST : div12_ff + 4'h1;
    nxt_div8  = ext_rise ? div8_ff + 3'h1 : div8_ff;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div12_ff <= ARCT_DIV12_RST;
      div8_ff  <= ARCT_DIV8_RST;
    end else begin
      div12_ff <= nxt_div12;
      div8_ff  <= nxt_div8;
    end
  end

  assign tick_div12 = (div12_ff == ARCT_DIV12_LAST);
  assign tick_ext8  = ext_rise & (div8_ff == ARCT_DIV8_LAST);

  always_comb begin
    case (ctrl_ff.alt_clock_sel)
      ARCT_ALT_DIV12A: alt_tick = tick_div12;
      ARCT_ALT_EXT8:   alt_tick = tick_ext8;
      ARCT_ALT_DIV12B: alt_tick = tick_div12;
      ARCT_ALT_CMP:    alt_tick = cmp_rise;
      default:         alt_tick = 1'b0;
    endcase
  end

  // the low select also clocks the full counter in 16-bit and capture mode
  assign tick_lo   = cksel_ff.low_core_clock_sel  | alt_tick;
  assign tick_hi   = cksel_ff.high_core_clock_sel | alt_tick;
  // capture trigger shares the alt select upper bit
  assign cap_event = ctrl_ff.capture_mode_en &
                     (ctrl_ff.alt_clock_sel[1] ? tick_ext8 : cmp_rise);

  // ****************************************************************
  // avalon-mm slave: one wait state on every access
  // ****************************************************************
  assign wr_take = avs_write & (bus_ff == ARCT_BUS_ACK);
  assign wr_lane = wr_take & avs_byteenable[0];

  always_comb begin
    nxt_bus   = ARCT_BUS_IDLE;
    nxt_rdata = rdata_ff;
    if ((avs_read | avs_write) && (bus_ff == ARCT_BUS_IDLE)) begin
      nxt_bus   = ARCT_BUS_ACK;
      nxt_rdata = ARCT_RD_ZERO;
      case (avs_address)
        ARCT_OFS_CTRL:  nxt_rdata[7:0] = ctrl_ff;
        ARCT_OFS_CKSEL: nxt_rdata[7:0] = cksel_ff;
        ARCT_OFS_RLLO:  nxt_rdata[7:0] = rl_lo_ff;
        ARCT_OFS_RLHI:  nxt_rdata[7:0] = rl_hi_ff;
        ARCT_OFS_CNTLO: nxt_rdata[7:0] = cnt_lo_ff;
        ARCT_OFS_CNTHI: nxt_rdata[7:0] = cnt_hi_ff;
        ARCT_OFS_IRQEN: nxt_rdata[0]   = irq_en_ff;
        default:        nxt_rdata      = ARCT_RD_ZERO;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & (bus_ff != ARCT_BUS_ACK);
  assign avs_readdata    = rdata_ff;

  // ****************************************************************
  // counter, reload, capture and flags
  // ****************************************************************
  always_comb begin
    nxt_cnt_lo = cnt_lo_ff;
    nxt_cnt_hi = cnt_hi_ff;
    nxt_rl_lo  = rl_lo_ff;
    nxt_rl_hi  = rl_hi_ff;
    set_h      = 1'b0;
    set_l      = 1'b0;
    if (ctrl_ff.split_mode_sel) begin
      if (tick_lo) begin
        if (cnt_lo_ff == ARCT_BYTE_MAX) begin
          nxt_cnt_lo = rl_lo_ff;
          set_l      = 1'b1;
        end else begin
          nxt_cnt_lo = cnt_lo_ff + ARCT_BYTE_ONE;
        end
      end
      if (ctrl_ff.run_high && tick_hi) begin
        if (cnt_hi_ff == ARCT_BYTE_MAX) begin
          nxt_cnt_hi = rl_hi_ff;
          set_h      = 1'b1;
        end else begin
          nxt_cnt_hi = cnt_hi_ff + ARCT_BYTE_ONE;
        end
      end
    end else if (ctrl_ff.run_high && tick_lo) begin
      set_l = (cnt_lo_ff == ARCT_BYTE_MAX);
      if ({cnt_hi_ff, cnt_lo_ff} == {ARCT_BYTE_MAX, ARCT_BYTE_MAX}) begin
        // capture mode keeps the reload bytes for the captured value
        if (ctrl_ff.capture_mode_en) begin
          {nxt_cnt_hi, nxt_cnt_lo} = ARCT_WORD_ZERO;
        end else begin
          {nxt_cnt_hi, nxt_cnt_lo} = {rl_hi_ff, rl_lo_ff};
          set_h                    = 1'b1;
        end
      end else begin
        {nxt_cnt_hi, nxt_cnt_lo} = 16'({cnt_hi_ff, cnt_lo_ff} + 16'h0001);
      end
    end
    if (cap_event) begin
      {nxt_rl_hi, nxt_rl_lo} = {cnt_hi_ff, cnt_lo_ff};
      set_h                  = 1'b1;
    end
    if (wr_lane) begin
      case (avs_address)
        ARCT_OFS_RLLO:  nxt_rl_lo  = avs_writedata[7:0];
        ARCT_OFS_RLHI:  nxt_rl_hi  = avs_writedata[7:0];
        ARCT_OFS_CNTLO: nxt_cnt_lo = avs_writedata[7:0];
        ARCT_OFS_CNTHI: nxt_cnt_hi = avs_writedata[7:0];
        default:        nxt_cnt_lo = nxt_cnt_lo;
      endcase
    end
  end

  // ****************************************************************
  // control registers; a hardware set beats a software clear
  // ****************************************************************
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_cksel  = cksel_ff;
    nxt_irq_en = irq_en_ff;
    if (wr_lane) begin
      case (avs_address)
        ARCT_OFS_CTRL:  nxt_ctrl   = arct_ctrl_s'(avs_writedata[7:0]);
        ARCT_OFS_CKSEL: nxt_cksel  = arct_cksel_s'({6'h00, avs_writedata[1:0]});
        ARCT_OFS_IRQEN: nxt_irq_en = avs_writedata[0];
        default:        nxt_irq_en = irq_en_ff;
      endcase
    end
    nxt_ctrl.ovf_flag_high = nxt_ctrl.ovf_flag_high | set_h;
    nxt_ctrl.ovf_flag_low  = nxt_ctrl.ovf_flag_low  | set_l;
    nxt_irq = irq_en_ff & (ctrl_ff.ovf_flag_high |
              (ctrl_ff.low_ovf_irq_en & ctrl_ff.ovf_flag_low));
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_ff    <= ARCT_BUS_IDLE;
      rdata_ff  <= ARCT_RD_ZERO;
      ctrl_ff   <= ARCT_CTRL_RST;
      cksel_ff  <= ARCT_CKSEL_RST;
      irq_en_ff <= 1'b0;
      irq_ff    <= 1'b0;
      cnt_lo_ff <= ARCT_BYTE_RST;
      cnt_hi_ff <= ARCT_BYTE_RST;
      rl_lo_ff  <= ARCT_BYTE_RST;
      rl_hi_ff  <= ARCT_BYTE_RST;
    end else begin
      bus_ff    <= nxt_bus;
      rdata_ff  <= nxt_rdata;
      ctrl_ff   <= nxt_ctrl;
      cksel_ff  <= nxt_cksel;
      irq_en_ff <= nxt_irq_en;
      irq_ff    <= nxt_irq;
      cnt_lo_ff <= nxt_cnt_lo;
      cnt_hi_ff <= nxt_cnt_hi;
      rl_lo_ff  <= nxt_rl_lo;
      rl_hi_ff  <= nxt_rl_hi;
    end
  end

  // irq is a level that follows the flags one cycle late
  assign timer_irq = irq_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_div12_period : assert property (
    @(posedge clk_sys) disable iff (rst)
    tick_div12 |=> !tick_div12 [*8] ##1 !tick_div12 ##1 !tick_div12 ##1 !tick_div12
    ##1 tick_div12)
    else $error("core divide tick not every twelve cycles");

  a_wrap_reload : assert property (
    @(posedge clk_sys) disable iff (rst)
    (!ctrl_ff.split_mode_sel && !ctrl_ff.capture_mode_en && ctrl_ff.run_high &&
     tick_lo && {cnt_hi_ff, cnt_lo_ff} == {ARCT_BYTE_MAX, ARCT_BYTE_MAX} && !wr_take)
    |=> {cnt_hi_ff, cnt_lo_ff} == $past({rl_hi_ff, rl_lo_ff}) && ctrl_ff.ovf_flag_high)
    else $error("16-bit wrap did not reload and flag");

  a_irq_high_flag : assert property (
    @(posedge clk_sys) disable iff (rst)
    (irq_en_ff && ctrl_ff.ovf_flag_high) |=> timer_irq)
    else $error("high flag did not raise interrupt");

  a_irq_low_flag : assert property (
    @(posedge clk_sys) disable iff (rst)
    (irq_en_ff && ctrl_ff.low_ovf_irq_en && ctrl_ff.ovf_flag_low) |=> timer_irq)
    else $error("low flag did not raise interrupt");

  a_split_low_reload : assert property (
    @(posedge clk_sys) disable iff (rst)
    (ctrl_ff.split_mode_sel && tick_lo && cnt_lo_ff == ARCT_BYTE_MAX && !wr_take)
    |=> cnt_lo_ff == $past(rl_lo_ff) && ctrl_ff.ovf_flag_low)
    else $error("split low byte did not reload");

  a_split_high_hold : assert property (
    @(posedge clk_sys) disable iff (rst)
    (ctrl_ff.split_mode_sel && !ctrl_ff.run_high && !wr_take) |=> $stable(cnt_hi_ff))
    else $error("stopped high byte moved");

  a_flag_sticky : assert property (
    @(posedge clk_sys) disable iff (rst)
    (ctrl_ff.ovf_flag_high && !wr_take) |=> ctrl_ff.ovf_flag_high)
    else $error("high flag cleared without a write");

  a_capture_copy : assert property (
    @(posedge clk_sys) disable iff (rst)
    (cap_event && !wr_take)
    |=> {rl_hi_ff, rl_lo_ff} == $past({cnt_hi_ff, cnt_lo_ff}) && ctrl_ff.ovf_flag_high)
    else $error("capture did not copy count");

  a_count_write : assert property (
    @(posedge clk_sys) disable iff (rst)
    (wr_lane && avs_address == ARCT_OFS_CNTLO) |=> cnt_lo_ff == $past(avs_writedata[7:0]))
    else $error("count low write lost");

endmodule // arct_top

// ### bench/arct_src_model.sv
// drives the comparator and external oscillator pins of the timer
// assumes the bench calls cmp_pulse from its clocked sequence
`timescale 1ns/100ps
module arct_src_model (
  input  logic clk_sys,
  output logic cmp1_in,
  output logic ext_osc_in
);
  logic [1:0] ph      = 2'h0;
  logic       cmp_lvl = 1'b0;

  // free running at a quarter of clk_sys; /8 is far slower than the count clock
  always @(posedge clk_sys) ph <= ph + 2'h1;
  assign ext_osc_in = ph[1];
  assign cmp1_in    = cmp_lvl;

  // one rise per call, held six cycles so the synchroniser cannot miss it
  task automatic cmp_pulse();
    @(posedge clk_sys);
    cmp_lvl <= 1'b1;
    repeat (6) @(posedge clk_sys);
    cmp_lvl <= 1'b0;
  endtask
endmodule // arct_src_model

// ### bench/test_autoreload_capture_timer.sv
// self-checking bench of the auto-reload capture timer against a register model
// assumes arct_top with its package and the pin model arct_src_model
`timescale 1ns/100ps
module test_autoreload_capture_timer
  import arct_pkg::*;
;
  // ********************************
  // signals and model state
  // ********************************
  localparam logic [7:0] MSK [8] = '{8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h00};
  // count windows: 243 cycles of core/12, ext/8, core/12, then a window of six comparator rises
  localparam logic [7:0] LO [4]  = '{8'h13, 8'h06, 8'h13, 8'h06};
  localparam logic [7:0] HI [4]  = '{8'h15, 8'h08, 8'h15, 8'h06};
  logic                   clk_sys        = 1'b0;
  logic                   rst            = 1'b1;
  logic [ARCT_ADDR_W-1:0] avs_address    = 5'h00;
  logic                   avs_read       = 1'b0;
  logic                   avs_write      = 1'b0;
  logic [31:0]            avs_writedata  = 32'h0000_0000;
  logic [3:0]             avs_byteenable = 4'h0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   cmp1_in;
  logic                   ext_osc_in;
  logic                   timer_irq;
  int                     n_errors       = 0;
  int                     checks_done    = 0;
  int                     cyc            = 0;
  int                     t0;
  logic [31:0]            seed           = 32'h0000_0031;
  logic [7:0]             m [8]          = '{default: 8'h00};
  logic [7:0]             q;
  logic [7:0]             rl;
  logic [7:0]             rh;
  logic [15:0]            c0;
  logic [15:0]            c1;

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  arct_top dut (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (avs_byteenable),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cmp1_in        (cmp1_in),
    .ext_osc_in     (ext_osc_in),
    .timer_irq      (timer_irq)
  );

  arct_src_model src (
    .clk_sys   (clk_sys),
    .cmp1_in   (cmp1_in),
    .ext_osc_in(ext_osc_in)
  );

  // ********************************
  // helpers
  // ********************************
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // request held until waitrequest is sampled low; a hang is left to the watchdog
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic be, output logic [7:0] rd_q);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_read       <= ~w;
    avs_write      <= w;
    avs_writedata  <= {24'h00_0000, d};
    avs_byteenable <= {3'h0, be};
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, 1'b1, x);
    m[a[4:2]] = d & MSK[a[4:2]];
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 8'h00, 1'b1, q);
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // poll for a capture, take both reload bytes, then clear the flag
  task automatic cap_read(input logic [7:0] ctl, output logic [15:0] v);
    q = 8'h00;
    for (int w = 0; w < 40 && q[7] !== 1'b1; w++) rd(ARCT_OFS_CTRL);
    chk({7'h00, q[7]}, 8'h01);
    rd(ARCT_OFS_RLLO);
    v[7:0] = q;
    rd(ARCT_OFS_RLHI);
    v[15:8] = q;
    wr(ARCT_OFS_CTRL, ctl);
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ********************************
  // scenarios
  // ********************************
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(5'(a * 4));
      chk(q, 8'h00);
      // ctrl kept away from run, split and capture so nothing moves meanwhile
      rl = rnd() & (a == 0 ? 8'h21 : 8'hFF);
      bus(1'b1, 5'(a * 4), rl, 1'b0, q);
      rd(5'(a * 4));
      chk(q, m[a]);
      wr(5'(a * 4), rl);
      rd(5'(a * 4));
      chk(q, m[a]);
    end
    wr(ARCT_OFS_IRQEN, 8'h01);
    wr(ARCT_OFS_CKSEL, 8'h01);
    for (int en = 0; en < 2; en++) begin
      wr(ARCT_OFS_CNTHI, 8'h00);
      wr(ARCT_OFS_CNTLO, 8'hF8);
      wr(ARCT_OFS_CTRL, en ? 8'h24 : 8'h04);
      cy(20);
      chk({7'h00, timer_irq}, 8'(en));
      rd(ARCT_OFS_CTRL);
      chk(q, en ? 8'h64 : 8'h44);
      rd(ARCT_OFS_CNTHI);
      chk(q, 8'h01);
      wr(ARCT_OFS_CTRL, 8'h00);
    end
    rl = rnd() & 8'h3F;
    rh = rnd() & 8'h7F;
    wr(ARCT_OFS_RLLO, rl);
    wr(ARCT_OFS_RLHI, rh);
    wr(ARCT_OFS_CNTHI, 8'hFF);
    wr(ARCT_OFS_CNTLO, 8'hF0);
    wr(ARCT_OFS_CTRL, 8'h04);
    cy(60);
    chk({7'h00, timer_irq}, 8'h01);
    rd(ARCT_OFS_CTRL);
    chk(q, 8'hC4);
    rd(ARCT_OFS_CNTHI);
    chk(q, rh);
    rd(ARCT_OFS_CNTLO);
    chk_rng(16'(q), 16'(rl) + 16'h0020, 16'(rl) + 16'h0050);
    wr(ARCT_OFS_CTRL, 8'h00);
    cy(3);
    chk({7'h00, timer_irq}, 8'h00);
    // split: high byte parked, low byte runs without run_high
    wr(ARCT_OFS_CKSEL, 8'h03);
    wr(ARCT_OFS_CNTHI, 8'hFC);
    wr(ARCT_OFS_CNTLO, 8'hFC);
    wr(ARCT_OFS_CTRL, 8'h08);
    cy(20);
    chk({7'h00, timer_irq}, 8'h00);
    rd(ARCT_OFS_CTRL);
    chk(q, 8'h48);
    rd(ARCT_OFS_CNTHI);
    chk(q, 8'hFC);
    rd(ARCT_OFS_CNTLO);
    chk_rng(16'(q), 16'(rl) + 16'h0010, 16'(rl) + 16'h0024);
    wr(ARCT_OFS_CTRL, 8'h2C);
    cy(10);
    chk({7'h00, timer_irq}, 8'h01);
    rd(ARCT_OFS_CTRL);
    chk(q, 8'hAC);
    rd(ARCT_OFS_CNTHI);
    chk_rng(16'(q), 16'(rh), 16'(rh) + 16'h0014);
    wr(ARCT_OFS_CTRL, 8'h00);
    wr(ARCT_OFS_CKSEL, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(ARCT_OFS_CNTLO, 8'h00);
      wr(ARCT_OFS_CNTHI, 8'h00);
      wr(ARCT_OFS_CTRL, 8'(4 + s));
      if (s == 3) begin
        repeat (6) begin
          cy(4);
          src.cmp_pulse();
        end
      end else begin
        cy(240);
      end
      wr(ARCT_OFS_CTRL, 8'h00);
      rd(ARCT_OFS_CNTLO);
      chk_rng(16'(q), 16'(LO[s]), 16'(HI[s]));
    end
    // capture against the core clock, split left at 0
    wr(ARCT_OFS_CKSEL, 8'h01);
    wr(ARCT_OFS_CTRL, 8'h14);
    src.cmp_pulse();
    t0 = cyc;
    chk({7'h00, timer_irq}, 8'h01);
    cap_read(8'h14, c0);
    while (cyc < t0 + 150) @(posedge clk_sys);
    src.cmp_pulse();
    cap_read(8'h14, c1);
    // the wait loop plus the pulse call span 157 edges between rises
    chk_rng(c1 - c0, 16'h009C, 16'h009E);
    wr(ARCT_OFS_CTRL, 8'h16);
    cap_read(8'h16, c0);
    cap_read(8'h16, c1);
    chk_rng(c1 - c0, 16'h0020, 16'h0022);
    wr(ARCT_OFS_CTRL, 8'h00);
    cy(3);
    chk({7'h00, timer_irq}, 8'h00);
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end
endmodule // test_autoreload_capture_timer
